// *** hdl/blsa_map.svh ***
// constants for the byte logic, shift and bit datapath
// assumes the decoder drives one operation code per request
// Contract
// - AND destination with register or immediate
// - OR destination with register or immediate
// - XOR destination with register or immediate
// - NOT replaces destination with complement
// - arithmetic shifts move register one place
// - logical shifts fill vacated bit zero
// - rotates plain in byte, extended through carry
// - bit set forces selected bit one
// - bit number from immediate or register
// - bit clear forces selected bit zero
// - bit invert toggles selected bit
// - bit test loads zero with inverse
// - carry ANDed with selected bit
// - carry ANDed with inverted selected bit
// - carry ORed with selected bit
// - carry ORed with inverted selected bit
// - inverted carry forms take immediate only
`ifndef BLSA_MAP_SVH
`define BLSA_MAP_SVH
// ---------------------------------------------
// widths and reset values
// ---------------------------------------------
`define BLSA_BYTE_W 8
`define BLSA_BITNO_W 3
`define BLSA_RESULT_RST 8'h00
`define BLSA_SIGN_BIT 7
`endif

// *** hdl/blsa_pkg.sv ***
// types for the byte logic, shift and bit datapath
// assumes nothing beyond the map header
package blsa_pkg;
   // operation codes presented by the decoder
   typedef enum logic [4:0] {
      BLSA_OP_NONE = 5'h00,
      BLSA_OP_AND = 5'h01,
      BLSA_OP_OR = 5'h02,
      BLSA_OP_XOR = 5'h03,
      BLSA_OP_NOT = 5'h04,
      BLSA_OP_ARITH_SHIFT_LEFT = 5'h05,
      BLSA_OP_ARITH_SHIFT_RIGHT = 5'h06,
      BLSA_OP_LOGIC_SHIFT_LEFT = 5'h07,
      BLSA_OP_LOGIC_SHIFT_RIGHT = 5'h08,
      BLSA_OP_ROTATE_LEFT = 5'h09,
      BLSA_OP_ROTATE_RIGHT = 5'h0a,
      BLSA_OP_ROTATE_LEFT_VIA_CARRY = 5'h0b,
      BLSA_OP_ROTATE_RIGHT_VIA_CARRY = 5'h0c,
      BLSA_OP_BIT_SET = 5'h0d,
      BLSA_OP_BIT_CLEAR = 5'h0e,
      BLSA_OP_BIT_INVERT = 5'h0f,
      BLSA_OP_BIT_TEST = 5'h10,
      BLSA_OP_CARRY_AND_BIT = 5'h11,
      BLSA_OP_CARRY_AND_INV_BIT = 5'h12,
      BLSA_OP_CARRY_OR_BIT = 5'h13,
      BLSA_OP_CARRY_OR_INV_BIT = 5'h14
   } blsa_op_e;
   // datapath states, one-hot
   typedef enum logic [1:0] {
      BLSA_ST_IDLE = 2'b01,
      BLSA_ST_DONE = 2'b10
   } blsa_state_e;
endpackage : blsa_pkg

// *** hdl/blsa_alu.sv ***
// byte datapath: logic, shift, rotate and bit manipulation, one result per request
// assumes the decoder holds operands valid in the request cycle and a memory
// operand was already read into dst_byte; the caller writes back on wr_reg or wr_mem
`include "blsa_map.svh"
module blsa_alu (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req,
   input wire blsa_pkg::blsa_op_e op,
   input wire logic [`BLSA_BYTE_W-1:0] dst_byte,
   input wire logic [`BLSA_BYTE_W-1:0] src_reg,
   input wire logic [`BLSA_BYTE_W-1:0] imm_byte,
   input wire logic use_imm,
   input wire logic bit_from_reg,
   input wire logic [`BLSA_BITNO_W-1:0] bit_imm,
   input wire logic target_mem,
   input wire logic carry_in,
   input wire logic zero_in,
   output logic done,
   output logic illegal,
   output logic [`BLSA_BYTE_W-1:0] result,
   output logic wr_reg,
   output logic wr_mem,
   output logic carry_out,
   output logic zero_out,
   output logic carry_we,
   output logic zero_we
);
   import blsa_pkg::*;

   // ---------------------------------------------
   // timing of one request
   // ---------------------------------------------
   // edge 0: req high, operands and op stand; the answer is computed in this cycle
   // edge 1: done pulses for one cycle with the write strobes of the operation
   // result, carry_out and zero_out stand until the next legal request replaces them
   // a refused request pulses done with illegal and leaves every held value alone
   // requests may follow every cycle; nothing is queued, so there is no back-pressure
   // limitation: a memory operand must already be read, the read half of the
   // read-modify-write sits with the caller

   // ---------------------------------------------
   // operand selection
   // ---------------------------------------------
   wire logic [`BLSA_BYTE_W-1:0] opnd_b; // second logic operand
   wire logic [`BLSA_BITNO_W-1:0] bit_no; // selected bit number
   wire logic [`BLSA_BYTE_W-1:0] bit_mask; // one-hot bit mask
   wire logic sel_bit; // value of selected bit
   wire logic inv_form; // inverted carry-combining forms
   wire logic bad_src; // register bit number on inverted form
   assign opnd_b = use_imm ? imm_byte : src_reg;
   assign bit_no = bit_from_reg ? src_reg[`BLSA_BITNO_W-1:0] : bit_imm;
   // one compare per bit: the mask is a plain decoder of the bit number
   for (genvar gi = 0; gi < `BLSA_BYTE_W; gi++) begin : g_mask
      assign bit_mask[gi] = (int'(bit_no) == gi);
   end
   assign sel_bit = dst_byte[bit_no];
   assign inv_form = (op == BLSA_OP_CARRY_AND_INV_BIT) || (op == BLSA_OP_CARRY_OR_INV_BIT);
   // register bit numbers are refused, not silently used, on the inverted forms
   assign bad_src = inv_form && bit_from_reg;

   // ---------------------------------------------
   // result calculation
   // ---------------------------------------------
   logic [`BLSA_BYTE_W-1:0] res_c; // byte result
   logic c_c; // new carry
   logic z_c; // new zero
   logic wb_c; // byte is written back
   logic cw_c; // carry written
   logic zw_c; // zero written
   always_comb begin
      res_c = dst_byte;
      c_c = carry_in;
      z_c = zero_in;
      wb_c = 1'b0;
      cw_c = 1'b0;
      zw_c = 1'b0;
      case (op)
         BLSA_OP_AND: begin
            res_c = dst_byte & opnd_b;
            wb_c = 1'b1;
         end
         BLSA_OP_OR: begin
            res_c = dst_byte | opnd_b;
            wb_c = 1'b1;
         end
         BLSA_OP_XOR: begin
            res_c = dst_byte ^ opnd_b;
            wb_c = 1'b1;
         end
         BLSA_OP_NOT: begin
            res_c = ~dst_byte;
            wb_c = 1'b1;
         end
         BLSA_OP_ARITH_SHIFT_LEFT: begin
            res_c = {dst_byte[6:0], 1'b0};
            c_c = dst_byte[`BLSA_SIGN_BIT];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_ARITH_SHIFT_RIGHT: begin
            // sign bit is kept so signed values halve correctly
            res_c = {dst_byte[`BLSA_SIGN_BIT], dst_byte[7:1]};
            c_c = dst_byte[0];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_LOGIC_SHIFT_LEFT: begin
            res_c = {dst_byte[6:0], 1'b0};
            c_c = dst_byte[7];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_LOGIC_SHIFT_RIGHT: begin
            res_c = {1'b0, dst_byte[7:1]};
            c_c = dst_byte[0];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_ROTATE_LEFT: begin
            res_c = {dst_byte[6:0], dst_byte[7]};
            c_c = dst_byte[7];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_ROTATE_RIGHT: begin
            res_c = {dst_byte[0], dst_byte[7:1]};
            c_c = dst_byte[0];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_ROTATE_LEFT_VIA_CARRY: begin
            // nine-bit loop: old carry enters bit 0
            res_c = {dst_byte[6:0], carry_in};
            c_c = dst_byte[7];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_ROTATE_RIGHT_VIA_CARRY: begin
            res_c = {carry_in, dst_byte[7:1]};
            c_c = dst_byte[0];
            wb_c = 1'b1;
            cw_c = 1'b1;
         end
         BLSA_OP_BIT_SET: begin
            res_c = dst_byte | bit_mask;
            wb_c = 1'b1;
         end
         BLSA_OP_BIT_CLEAR: begin
            res_c = dst_byte & ~bit_mask;
            wb_c = 1'b1;
         end
         BLSA_OP_BIT_INVERT: begin
            res_c = dst_byte ^ bit_mask;
            wb_c = 1'b1;
         end
         BLSA_OP_BIT_TEST: begin
            z_c = ~sel_bit;
            zw_c = 1'b1;
         end
         BLSA_OP_CARRY_AND_BIT: begin
            c_c = carry_in & sel_bit;
            cw_c = 1'b1;
         end
         BLSA_OP_CARRY_AND_INV_BIT: begin
            c_c = carry_in & ~sel_bit;
            cw_c = 1'b1;
         end
         BLSA_OP_CARRY_OR_BIT: begin
            c_c = carry_in | sel_bit;
            cw_c = 1'b1;
         end
         BLSA_OP_CARRY_OR_INV_BIT: begin
            c_c = carry_in | ~sel_bit;
            cw_c = 1'b1;
         end
         default: begin
            res_c = dst_byte;
         end
      endcase
   end

   // ---------------------------------------------
   // acceptance
   // ---------------------------------------------
   wire logic take; // request accepted at this edge
   wire logic op_known; // code is anything but the none code
   wire logic ok; // request is legal and may write
   wire logic apply; // legal request: held values are replaced
   assign take = req;
   assign op_known = (op != BLSA_OP_NONE);
   // a none code is refused rather than ignored, so a decoder slip shows as illegal
   assign ok = !bad_src && op_known;
   assign apply = take && ok;

   // ---------------------------------------------
   // sequencing
   // ---------------------------------------------
   blsa_state_e state_r; // idle or answer presented
   blsa_state_e state_nxt; // state after the coming edge
   // the done state lasts one cycle, or follows itself while requests arrive back to back
   always_comb begin
      state_nxt = BLSA_ST_IDLE;
      case (state_r)
         BLSA_ST_IDLE: begin
            // a request turns into an answer one cycle later
            state_nxt = take ? BLSA_ST_DONE : BLSA_ST_IDLE;
         end
         BLSA_ST_DONE: begin
            // no recovery cycle: a new request may stand while the answer is shown
            state_nxt = take ? BLSA_ST_DONE : BLSA_ST_IDLE;
         end
         default: begin
            // a code that is not one-hot falls back to idle
            state_nxt = BLSA_ST_IDLE;
         end
      endcase
   end

   // state register; reset leaves no answer pending
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= BLSA_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------
   // held answer: result and flags
   // ---------------------------------------------
   logic [`BLSA_BYTE_W-1:0] result_r; // last legal byte result
   logic carry_r; // last legal carry value
   logic zero_r; // last legal zero value
   wire logic [`BLSA_BYTE_W-1:0] result_nxt; // byte after the coming edge
   wire logic carry_nxt; // carry after the coming edge
   wire logic zero_nxt; // zero after the coming edge
   // values are kept rather than cleared so the caller may write back late
   assign result_nxt = apply ? res_c : result_r;
   assign carry_nxt = apply ? c_c : carry_r;
   assign zero_nxt = apply ? z_c : zero_r;

   // held values change only on a legal request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= `BLSA_RESULT_RST;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         result_r <= result_nxt;
         carry_r <= carry_nxt;
         zero_r <= zero_nxt;
      end
   end

   // ---------------------------------------------
   // one-cycle strobes
   // ---------------------------------------------
   logic illegal_r; // refusal shown with done
   logic wr_reg_r; // register write-back
   logic wr_mem_r; // memory write-back
   logic carry_we_r; // carry flag update
   logic zero_we_r; // zero flag update
   wire logic illegal_nxt;
   wire logic wr_reg_nxt;
   wire logic wr_mem_nxt;
   wire logic carry_we_nxt;
   wire logic zero_we_nxt;
   // a refused request writes nothing at all
   assign illegal_nxt = take && !ok;
   // the byte goes to exactly one destination, never to both
   assign wr_reg_nxt = apply && wb_c && !target_mem;
   assign wr_mem_nxt = apply && wb_c && target_mem;
   // flag-only operations leave wb_c low, so they raise no byte strobe
   assign carry_we_nxt = apply && cw_c;
   assign zero_we_nxt = apply && zw_c;

   // strobes fall again after one cycle unless the next request raises them
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         illegal_r <= 1'b0;
         wr_reg_r <= 1'b0;
         wr_mem_r <= 1'b0;
         carry_we_r <= 1'b0;
         zero_we_r <= 1'b0;
      end else begin
         illegal_r <= illegal_nxt;
         wr_reg_r <= wr_reg_nxt;
         wr_mem_r <= wr_mem_nxt;
         carry_we_r <= carry_we_nxt;
         zero_we_r <= zero_we_nxt;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // done is decoded from the state so it cannot disagree with the sequencing
   assign done = (state_r == BLSA_ST_DONE);
   assign illegal = illegal_r;
   assign wr_reg = wr_reg_r;
   assign wr_mem = wr_mem_r;
   assign carry_we = carry_we_r;
   assign zero_we = zero_we_r;
   // data outputs come straight from flip-flops
   assign result = result_r;
   assign carry_out = carry_r;
   assign zero_out = zero_r;
endmodule : blsa_alu

// *** verification/blsa_alu_monitor.sv ***
// checker for blsa_alu: strobes, flags and results tied to their causes
// assumes one clock domain and rst_n active low
module blsa_alu_monitor (
   input wire logic clk_sys, rst_n, req, use_imm, bit_from_reg, target_mem,
   input wire blsa_pkg::blsa_op_e op,
   input wire logic [2:0] bit_imm,
   input wire logic [7:0] dst_byte, src_reg, imm_byte, result,
   input wire logic done, illegal, wr_reg, wr_mem, carry_out, zero_out, carry_we, zero_we
);
   timeunit 1ns;
   timeprecision 1ns;
   import blsa_pkg::*;
   // ------------------------------------------
   // helpers: expected values from the request
   // ------------------------------------------
   wire logic [2:0] bno = bit_from_reg ? src_reg[2:0] : bit_imm; // chosen bit number
   wire logic sel = dst_byte[bno];
   wire logic [7:0] and_v = dst_byte & src_reg;
   wire logic [7:0] or_v = dst_byte | imm_byte;
   wire logic [7:0] set_v = dst_byte | (8'h01 << bno);
   wire logic inv_op = op == BLSA_OP_CARRY_AND_INV_BIT || op == BLSA_OP_CARRY_OR_INV_BIT;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------
   // assertions
   // ------------------------------------------
   a_done_next: assert property (req |=> done)
      else $error("done missing after request");
   a_quiet_idle: assert property (!req |=> !done && !wr_reg && !wr_mem)
      else $error("strobe without request");
   a_and_reg: assert property (req && op == BLSA_OP_AND && !use_imm |=> result == $past(and_v))
      else $error("and result wrong");
   a_or_imm: assert property (req && op == BLSA_OP_OR && use_imm |=> result == $past(or_v))
      else $error("or result wrong");
   a_not_inv: assert property (req && op == BLSA_OP_NOT |=> result == ~$past(dst_byte))
      else $error("not result wrong");
   a_lsr_fill: assert property (req && op == BLSA_OP_LOGIC_SHIFT_RIGHT |=> !result[7] && carry_we)
      else $error("logical shift fill wrong");
   a_test_zero: assert property (req && op == BLSA_OP_BIT_TEST |=>
      zero_we && !wr_reg && !wr_mem && zero_out == !$past(sel))
      else $error("bit test flag wrong");
   a_inv_refused: assert property (req && inv_op && bit_from_reg |=> illegal && !carry_we && $stable(carry_out))
      else $error("register bit number accepted");
   a_set_mem: assert property (req && op == BLSA_OP_BIT_SET && target_mem |=>
      wr_mem && !wr_reg && result == $past(set_v))
      else $error("memory bit set wrong");
   c_test: cover property (req && op == BLSA_OP_BIT_TEST && bit_from_reg);
   c_refuse: cover property (req && inv_op && bit_from_reg);
   c_mem: cover property (req && target_mem);
   c_none: cover property (req && op == BLSA_OP_NONE);
endmodule : blsa_alu_monitor

bind blsa_alu blsa_alu_monitor i_mon (.*);

// *** verification/blsa_mem_model.sv ***
// memory byte behind the datapath: takes the whole byte on a write strobe
// assumes wr_mem pulses for one cycle with result valid
module blsa_mem_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_mem,
   input wire logic [7:0] result,
   output logic [7:0] mem_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   // whole byte rewritten, never a single bit; reset loads a known start byte
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) mem_byte <= 8'h10;
      else if (wr_mem) mem_byte <= result;
   end
endmodule : blsa_mem_model

// *** verification/tb.sv ***
// self-checking bench for blsa_alu: table of ops, then hand tests
// assumes the memory model and the bound checker
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import blsa_pkg::*;
   typedef struct packed {blsa_op_e op; logic [7:0] d, s; logic ui, ci; logic [1:0] k; logic [7:0] er; logic ec;} blsa_row_s;
   logic clk_sys = 0, rst_n = 0, req = 0, use_imm = 0, bit_from_reg = 0, target_mem = 0, carry_in = 0, zero_in = 0;
   blsa_op_e op = BLSA_OP_NONE;
   logic [7:0] dst_byte = 8'h00, src_reg = 8'h00, imm_byte = 8'h00;
   logic [2:0] bit_imm = 3'h0;
   wire logic done, illegal, wr_reg, wr_mem, carry_out, zero_out, carry_we, zero_we;
   wire logic [7:0] result, mem_byte;
   int n_fail = 0, samples_checked = 0;
   // k bit 0 checks result, bit 1 checks carry
   blsa_row_s rows [19] = '{
      '{BLSA_OP_AND, 8'hf0, 8'h3c, 0, 0, 1, 8'h30, 0}, '{BLSA_OP_OR, 8'hf0, 8'h0f, 1, 0, 1, 8'hff, 0},
      '{BLSA_OP_XOR, 8'hff, 8'h0f, 0, 0, 1, 8'hf0, 0}, '{BLSA_OP_NOT, 8'h5a, 8'h00, 0, 0, 1, 8'ha5, 0},
      '{BLSA_OP_ARITH_SHIFT_LEFT, 8'h81, 8'h00, 0, 0, 3, 8'h02, 1},
      '{BLSA_OP_ARITH_SHIFT_RIGHT, 8'h81, 8'h00, 0, 0, 3, 8'hc0, 1},
      '{BLSA_OP_LOGIC_SHIFT_LEFT, 8'h41, 8'h00, 0, 0, 3, 8'h82, 0},
      '{BLSA_OP_LOGIC_SHIFT_RIGHT, 8'h81, 8'h00, 0, 0, 3, 8'h40, 1},
      '{BLSA_OP_ROTATE_LEFT, 8'h81, 8'h00, 0, 0, 3, 8'h03, 1},
      '{BLSA_OP_ROTATE_RIGHT, 8'h81, 8'h00, 0, 0, 3, 8'hc0, 1},
      '{BLSA_OP_ROTATE_LEFT_VIA_CARRY, 8'h01, 8'h00, 0, 1, 3, 8'h03, 0},
      '{BLSA_OP_ROTATE_RIGHT_VIA_CARRY, 8'h01, 8'h00, 0, 1, 3, 8'h80, 1},
      '{BLSA_OP_BIT_SET, 8'h00, 8'h07, 0, 0, 1, 8'h80, 0}, '{BLSA_OP_BIT_CLEAR, 8'hff, 8'h00, 0, 0, 1, 8'hfe, 0},
      '{BLSA_OP_BIT_INVERT, 8'h0f, 8'h03, 0, 0, 1, 8'h07, 0},
      '{BLSA_OP_CARRY_AND_BIT, 8'h04, 8'h02, 0, 1, 2, 8'h00, 1},
      '{BLSA_OP_CARRY_AND_INV_BIT, 8'h04, 8'h02, 0, 1, 2, 8'h00, 0},
      '{BLSA_OP_CARRY_OR_BIT, 8'h00, 8'h05, 0, 0, 2, 8'h00, 0},
      '{BLSA_OP_CARRY_OR_INV_BIT, 8'h00, 8'h05, 0, 0, 2, 8'h00, 1}};
   blsa_alu i_dut (.*);
   blsa_mem_model i_mem (.*);
   always #25 clk_sys = ~clk_sys;
   // ------------------------------------------
   // one request; src differs from imm when ui, bit_imm from src when bfr, so a wrong select shows
   // ------------------------------------------
   task automatic go(blsa_op_e o, logic [7:0] d, s, logic ui, ci, bfr, mem);
      op = o;
      dst_byte = d;
      imm_byte = s;
      src_reg = ui ? ~s : s;
      bit_imm = bfr ? ~s[2:0] : s[2:0];
      use_imm = ui;
      carry_in = ci;
      bit_from_reg = bfr;
      target_mem = mem;
      req = 1;
      @(posedge clk_sys);
      #5;
   endtask : go
   task give_verdict;
      $display("checked=%0d failed=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // watchdog: whole run needs about 30 cycles
   initial begin
      #20us;
      n_fail++;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      #5 rst_n = 1;
      `CHK(done, 1'b0)
      `CHK(result, 8'h00)
      // table rows run back to back, req held high
      foreach (rows[i]) begin
         go(rows[i].op, rows[i].d, rows[i].s, rows[i].ui, rows[i].ci, 0, 0);
         `CHK(done, 1'b1)
         `CHK({wr_reg, carry_we}, {rows[i].k[0], rows[i].k[1]})
         if (rows[i].k[0]) `CHK(result, rows[i].er)
         if (rows[i].k[1]) `CHK(carry_out, rows[i].ec)
      end
      $display("table finished");
      go(BLSA_OP_BIT_TEST, 8'h08, 8'h03, 0, 0, 1, 0);
      `CHK(zero_out, 1'b0)
      `CHK(wr_reg, 1'b0)
      go(BLSA_OP_BIT_TEST, 8'h20, 8'h02, 0, 0, 1, 0);
      `CHK(zero_out, 1'b1)
      $display("bit test finished");
      go(BLSA_OP_CARRY_AND_INV_BIT, 8'h00, 8'h00, 0, 1, 1, 0);
      `CHK({illegal, carry_we}, 2'b10)
      $display("refusal finished");
      go(BLSA_OP_BIT_SET, mem_byte, 8'h00, 0, 0, 0, 1);
      `CHK({wr_mem, wr_reg}, 2'b10)
      req = 0;
      @(posedge clk_sys);
      #5;
      `CHK(mem_byte, 8'h11)
      `CHK(done, 1'b0)
      $display("memory finished");
      go(BLSA_OP_NONE, 8'h55, 8'h00, 0, 0, 0, 0);
      `CHK({done, illegal, wr_reg, carry_we}, 4'b1100)
      `CHK(result, 8'h11)
      $display("refused code finished");
      go(BLSA_OP_ROTATE_RIGHT, 8'h01, 8'h00, 0, 0, 0, 0);
      `CHK({result, carry_out}, 9'h101)
      req = 0;
      rst_n = 0;
      @(posedge clk_sys);
      #5;
      `CHK({done, wr_reg, carry_we, result, carry_out}, 12'h000)
      rst_n = 1;
      go(BLSA_OP_AND, 8'hf0, 8'h3c, 0, 0, 0, 0);
      `CHK({done, result}, 9'h130)
      $display("reset finished");
      give_verdict;
   end
endmodule : tb
